// ---- hw/cesg_pkg.sv ----
// package: register map, field positions and reset values for the client event status block
`default_nettype none
package cesg_pkg;
	localparam int unsigned CESG_ADDR_W = 12;
	localparam logic [11:0] CESG_FLAGS_OFF = 12'h080;
	localparam logic [11:0] CESG_MASK_OFF = 12'h084;
	localparam logic [11:0] CESG_LAST_OFF = 12'h088;
	localparam logic [11:0] CESG_EVSEL_OFF = 12'h08C;
	localparam logic [31:0] CESG_FLAGS_RST = 32'h0000_0000;
	localparam logic [31:0] CESG_MASK_RST = 32'h0000_0000;
	localparam logic [31:0] CESG_EVSEL_RST = 32'h0000_0000;
	// flag positions
	localparam int unsigned CAP2_ANCILLARY_B_BIT = 29;
	localparam int unsigned CAP2_ANCILLARY_A_BIT = 28;
	localparam int unsigned CAP1_ANCILLARY_B_BIT = 27;
	localparam int unsigned CAP1_ANCILLARY_A_BIT = 26;
	localparam int unsigned TRANSCODE2_LUMA_BIT = 25;
	localparam int unsigned TRANSCODE2_CHROMA_BIT = 24;
	localparam int unsigned TRANSCODE1_LUMA_BIT = 23;
	localparam int unsigned TRANSCODE1_CHROMA_BIT = 22;
	localparam int unsigned WRITEBACK_OUT_BIT = 21;
	localparam int unsigned PORT_CTL_BIT = 20;
	localparam int unsigned BLANKING_SD_BIT = 19;
	localparam int unsigned CESG_LO_BIT = 19;
	localparam int unsigned CESG_HI_BIT = 29;
	localparam int unsigned CESG_NFLAGS = 11;
	// implemented bits: 29..19
	localparam logic [31:0] CESG_IMPL_MASK = 32'h3FF8_0000;
	// capture-side clients, default event is end of frame received
	localparam logic [31:0] CESG_CAPTURE_MASK = 32'h3C20_0000;
	// fetch-side clients, default event is end of frame sent
	localparam logic [31:0] CESG_FETCH_MASK = 32'h03D8_0000;
endpackage
`default_nettype wire

// ---- hw/cesg_status.sv ----
// top: group-one client event status register with mask, interrupt and apb slave
//
// Contract
// [RULE_01] status register sits at offset 0x80 and resets to all zeros
// [RULE_02] a flag sets when its client reaches its descriptor-configured event
// [RULE_03] capture clients 29..26, 21 default to end of frame received
// [RULE_04] fetch clients 25..22, 20, 19 default to end of frame sent
// [RULE_05] a set flag stays set until software clears it
// [RULE_06] writing one clears exactly those bits; zeros leave bits alone
// [RULE_07] ancillary capture flags at bits 29, 28, 27, 26
// [RULE_08] transcode fetch flags at bits 25, 24, 23, 22
// [RULE_09] writeback output flag at bit 21, capture-side default
// [RULE_10] port control flag at bit 20, blanking sd data at bit 19
// [RULE_11] bits 31, 30 read zero and ignore writes; 18..0 read zero here
// [RULE_12] a set flag with its mask bit one drives interrupt zero high
//
// The APB register port was chosen for this implementation.
`default_nettype none
module cesg_status
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cesg_pkg::CESG_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] desc_event,
	input wire logic [31:0] desc_valid,
	input wire logic [31:0] eof_received,
	input wire logic [31:0] eof_sent,
	output logic dma_irq_zero
);
	import cesg_pkg::*;

	logic [31:0] flags_q;
	logic [31:0] flags_d;
	logic [31:0] mask_q;
	logic [31:0] mask_d;
	logic [31:0] configured_q;
	logic [31:0] configured_d;
	logic [31:0] last_q;
	logic irq_q;

	// keep only implemented bit positions; reserved ones never store
	function automatic logic [31:0] impl_only(input logic [31:0] v);
		impl_only = v & CESG_IMPL_MASK;
	endfunction

	// bus decode; single-cycle answer, so pready is tied high by design
	wire access_w = psel && penable;
	wire wr_w = access_w && pwrite;
	wire sel_flags = (paddr == CESG_FLAGS_OFF); // [RULE_01]
	wire sel_mask = (paddr == CESG_MASK_OFF);
	wire sel_last = (paddr == CESG_LAST_OFF);
	wire sel_evsel = (paddr == CESG_EVSEL_OFF);
	wire mapped_w = sel_flags || sel_mask || sel_last || sel_evsel;
	assign pready = 1'b1;
	assign pslverr = access_w && !mapped_w;

	// a client that has received a descriptor stops using its default event
	assign configured_d = impl_only(configured_q | desc_valid);

	// event per client: descriptor event once configured, otherwise side default
	wire [31:0] default_ev = (eof_received & CESG_CAPTURE_MASK) // [RULE_03] [RULE_09]
		| (eof_sent & CESG_FETCH_MASK); // [RULE_04] [RULE_10]
	wire [31:0] client_ev = impl_only((desc_event & configured_q)
		| (default_ev & ~configured_q)); // [RULE_02] [RULE_07] [RULE_08]

	// write-one-to-clear; a same-cycle event wins over the clear
	wire [31:0] clr_w = (wr_w && sel_flags) ? pwdata : 32'h0000_0000; // [RULE_06]
	assign flags_d = impl_only((flags_q & ~clr_w) | client_ev); // [RULE_05] [RULE_11]

	// mask next value, shared by the mask flop and the interrupt flop
	assign mask_d = (wr_w && sel_mask) ? impl_only(pwdata) : mask_q;

	// flag, mask, configured tracking
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			flags_q <= CESG_FLAGS_RST; // [RULE_01]
			mask_q <= CESG_MASK_RST;
			configured_q <= CESG_EVSEL_RST;
			last_q <= 32'h0000_0000;
		end else begin
			flags_q <= flags_d;
			configured_q <= configured_d;
			mask_q <= mask_d;
			if (|client_ev) begin
				last_q <= client_ev;
			end
		end
	end

	// registered from next values, so the level tracks the masked flags with no lag
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(flags_d & mask_d); // [RULE_12]
		end
	end
	assign dma_irq_zero = irq_q;

	// read mux, unmapped reads return zero
	wire [31:0] rd_mux = sel_flags ? flags_q :
		sel_mask ? mask_q :
		sel_last ? last_q :
		sel_evsel ? configured_q : 32'h0000_0000;

	// read data held in a flop, loaded in the setup cycle
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// reserved bits never read as one
	property p_reserved_zero;
		@(posedge mclk) disable iff (!resetn)
		(flags_q & ~CESG_IMPL_MASK) == 32'h0000_0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // [RULE_11]

	// flag holds unless a one is written to it
	property p_sticky;
		@(posedge mclk) disable iff (!resetn)
		(flags_q[CAP1_ANCILLARY_A_BIT] && !(wr_w && sel_flags && pwdata[CAP1_ANCILLARY_A_BIT]))
		|=> flags_q[CAP1_ANCILLARY_A_BIT];
	endproperty
	a_sticky: assert property (p_sticky) else $error("flag dropped without clear"); // [RULE_05]

	// clear of a quiet flag takes effect next cycle
	property p_clear;
		@(posedge mclk) disable iff (!resetn)
		(wr_w && sel_flags && pwdata[TRANSCODE2_LUMA_BIT] && !client_ev[TRANSCODE2_LUMA_BIT])
		|=> !flags_q[TRANSCODE2_LUMA_BIT];
	endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared"); // [RULE_06]

	// unconfigured capture client sets on received end of frame
	property p_cap_default;
		@(posedge mclk) disable iff (!resetn)
		(!configured_q[WRITEBACK_OUT_BIT] && eof_received[WRITEBACK_OUT_BIT])
		|=> flags_q[WRITEBACK_OUT_BIT];
	endproperty
	a_cap_default: assert property (p_cap_default) else $error("capture default missed"); // [RULE_03]

	// unconfigured fetch client sets on sent end of frame
	property p_fetch_default;
		@(posedge mclk) disable iff (!resetn)
		(!configured_q[BLANKING_SD_BIT] && eof_sent[BLANKING_SD_BIT])
		|=> flags_q[BLANKING_SD_BIT];
	endproperty
	a_fetch_default: assert property (p_fetch_default) else $error("fetch default missed"); // [RULE_04]

	// configured client follows its descriptor event
	property p_desc_event;
		@(posedge mclk) disable iff (!resetn)
		(configured_q[PORT_CTL_BIT] && desc_event[PORT_CTL_BIT]) |=> flags_q[PORT_CTL_BIT];
	endproperty
	a_desc_event: assert property (p_desc_event) else $error("descriptor event missed"); // [RULE_02]

	// interrupt is high whenever an unmasked flag is set
	sequence s_masked_set;
		|(flags_q & mask_q);
	endsequence
	property p_irq;
		@(posedge mclk) disable iff (!resetn)
		s_masked_set |-> dma_irq_zero;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised"); // [RULE_12]

	// no interrupt without a masked flag
	property p_irq_cause;
		@(posedge mclk) disable iff (!resetn)
		dma_irq_zero |-> s_masked_set;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("spurious interrupt"); // [RULE_12]

	// bit placement of capture flag 29 on received end of frame
	property p_anc_bits;
		@(posedge mclk) disable iff (!resetn)
		(!configured_q[CAP2_ANCILLARY_B_BIT] && eof_received[CAP2_ANCILLARY_B_BIT])
		|=> flags_q[CAP2_ANCILLARY_B_BIT];
	endproperty
	a_anc_bits: assert property (p_anc_bits) else $error("ancillary flag misplaced"); // [RULE_07]

	// the mask never holds a reserved bit, so it cannot raise a phantom interrupt
	property p_mask_rsvd;
		@(posedge mclk) disable iff (!resetn)
		(mask_q & ~CESG_IMPL_MASK) == 32'h0000_0000;
	endproperty
	a_mask_rsvd: assert property (p_mask_rsvd) else $error("reserved mask bit set"); // [RULE_11]

	// every read word keeps the reserved positions at zero
	property p_read_rsvd;
		@(posedge mclk) disable iff (!resetn)
		(prdata & ~CESG_IMPL_MASK) == 32'h0000_0000;
	endproperty
	a_read_rsvd: assert property (p_read_rsvd) else $error("reserved read bit set"); // [RULE_11]

	// a flag read returns the register as it stood in the setup cycle
	sequence s_flags_setup;
		psel && !penable && !pwrite && sel_flags;
	endsequence
	property p_flags_read;
		@(posedge mclk) disable iff (!resetn)
		s_flags_setup |=> (prdata == $past(flags_q));
	endproperty
	a_flags_read: assert property (p_flags_read) else $error("flag read wrong"); // [RULE_01]

	// second capture port channel a sets on received end of frame
	property p_cap2_anc_a;
		@(posedge mclk) disable iff (!resetn)
		(!configured_q[CAP2_ANCILLARY_A_BIT] && eof_received[CAP2_ANCILLARY_A_BIT])
		|=> flags_q[CAP2_ANCILLARY_A_BIT];
	endproperty
	a_cap2_anc_a: assert property (p_cap2_anc_a) else $error("bit 28 missed"); // [RULE_07]

	// first capture port channel b sets on received end of frame
	property p_cap1_anc_b;
		@(posedge mclk) disable iff (!resetn)
		(!configured_q[CAP1_ANCILLARY_B_BIT] && eof_received[CAP1_ANCILLARY_B_BIT])
		|=> flags_q[CAP1_ANCILLARY_B_BIT];
	endproperty
	a_cap1_anc_b: assert property (p_cap1_anc_b) else $error("bit 27 missed"); // [RULE_07]

	// first capture port channel a sets on received end of frame
	property p_cap1_anc_a;
		@(posedge mclk) disable iff (!resetn)
		(!configured_q[CAP1_ANCILLARY_A_BIT] && eof_received[CAP1_ANCILLARY_A_BIT])
		|=> flags_q[CAP1_ANCILLARY_A_BIT];
	endproperty
	a_cap1_anc_a: assert property (p_cap1_anc_a) else $error("bit 26 missed"); // [RULE_07]

	// transcode path two luma sets on sent end of frame
	property p_tc2_luma;
		@(posedge mclk) disable iff (!resetn)
		(!configured_q[TRANSCODE2_LUMA_BIT] && eof_sent[TRANSCODE2_LUMA_BIT])
		|=> flags_q[TRANSCODE2_LUMA_BIT];
	endproperty
	a_tc2_luma: assert property (p_tc2_luma) else $error("bit 25 missed"); // [RULE_08]

	// transcode path two chroma sets on sent end of frame
	property p_tc2_chroma;
		@(posedge mclk) disable iff (!resetn)
		(!configured_q[TRANSCODE2_CHROMA_BIT] && eof_sent[TRANSCODE2_CHROMA_BIT])
		|=> flags_q[TRANSCODE2_CHROMA_BIT];
	endproperty
	a_tc2_chroma: assert property (p_tc2_chroma) else $error("bit 24 missed"); // [RULE_08]

	// transcode path one luma sets on sent end of frame
	property p_tc1_luma;
		@(posedge mclk) disable iff (!resetn)
		(!configured_q[TRANSCODE1_LUMA_BIT] && eof_sent[TRANSCODE1_LUMA_BIT])
		|=> flags_q[TRANSCODE1_LUMA_BIT];
	endproperty
	a_tc1_luma: assert property (p_tc1_luma) else $error("bit 23 missed"); // [RULE_08]

	// transcode path one chroma sets on sent end of frame
	property p_tc1_chroma;
		@(posedge mclk) disable iff (!resetn)
		(!configured_q[TRANSCODE1_CHROMA_BIT] && eof_sent[TRANSCODE1_CHROMA_BIT])
		|=> flags_q[TRANSCODE1_CHROMA_BIT];
	endproperty
	a_tc1_chroma: assert property (p_tc1_chroma) else $error("bit 22 missed"); // [RULE_08]

	// port control client is fetch side and sets on sent end of frame
	property p_port_ctl;
		@(posedge mclk) disable iff (!resetn)
		(!configured_q[PORT_CTL_BIT] && eof_sent[PORT_CTL_BIT])
		|=> flags_q[PORT_CTL_BIT];
	endproperty
	a_port_ctl: assert property (p_port_ctl) else $error("bit 20 missed"); // [RULE_10]

	// writeback output is capture side, so a sent end of frame leaves it alone
	property p_wb_side;
		@(posedge mclk) disable iff (!resetn)
		(!flags_q[WRITEBACK_OUT_BIT] && !configured_q[WRITEBACK_OUT_BIT]
			&& !eof_received[WRITEBACK_OUT_BIT] && eof_sent[WRITEBACK_OUT_BIT])
		|=> !flags_q[WRITEBACK_OUT_BIT];
	endproperty
	a_wb_side: assert property (p_wb_side) else $error("bit 21 wrong side"); // [RULE_09]

	// blanking data is fetch side, so a received end of frame leaves it alone
	property p_blank_side;
		@(posedge mclk) disable iff (!resetn)
		(!flags_q[BLANKING_SD_BIT] && !configured_q[BLANKING_SD_BIT]
			&& !eof_sent[BLANKING_SD_BIT] && eof_received[BLANKING_SD_BIT])
		|=> !flags_q[BLANKING_SD_BIT];
	endproperty
	a_blank_side: assert property (p_blank_side) else $error("bit 19 wrong side"); // [RULE_04]

	// once configured, the default end of frame no longer sets the flag
	property p_cfg_no_default;
		@(posedge mclk) disable iff (!resetn)
		(configured_q[CAP2_ANCILLARY_B_BIT] && !flags_q[CAP2_ANCILLARY_B_BIT]
			&& !desc_event[CAP2_ANCILLARY_B_BIT] && eof_received[CAP2_ANCILLARY_B_BIT])
		|=> !flags_q[CAP2_ANCILLARY_B_BIT];
	endproperty
	a_cfg_no_default: assert property (p_cfg_no_default) else $error("default used"); // [RULE_02]

	// no event of either kind, no flag
	property p_no_event;
		@(posedge mclk) disable iff (!resetn)
		(!flags_q[TRANSCODE1_LUMA_BIT] && !eof_sent[TRANSCODE1_LUMA_BIT]
			&& !desc_event[TRANSCODE1_LUMA_BIT])
		|=> !flags_q[TRANSCODE1_LUMA_BIT];
	endproperty
	a_no_event: assert property (p_no_event) else $error("flag set with no event"); // [RULE_02]

	// an event in the cycle of a clear wins, so no event is ever lost
	property p_set_wins;
		@(posedge mclk) disable iff (!resetn)
		(wr_w && sel_flags && pwdata[TRANSCODE2_CHROMA_BIT]
			&& !configured_q[TRANSCODE2_CHROMA_BIT] && eof_sent[TRANSCODE2_CHROMA_BIT])
		|=> flags_q[TRANSCODE2_CHROMA_BIT];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost to clear"); // [RULE_06]

	// a zero written to a set flag leaves it set
	property p_zero_keeps;
		@(posedge mclk) disable iff (!resetn)
		(flags_q[BLANKING_SD_BIT] && wr_w && sel_flags && !pwdata[BLANKING_SD_BIT])
		|=> flags_q[BLANKING_SD_BIT];
	endproperty
	a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared"); // [RULE_06]

	// an event followed later by a quiet clear leaves the flag low
	sequence s_wb_event;
		!configured_q[WRITEBACK_OUT_BIT] && eof_received[WRITEBACK_OUT_BIT];
	endsequence
	sequence s_wb_clear;
		wr_w && sel_flags && pwdata[WRITEBACK_OUT_BIT] && !client_ev[WRITEBACK_OUT_BIT];
	endsequence
	property p_wb_clear;
		@(posedge mclk) disable iff (!resetn)
		s_wb_event ##[1:40] s_wb_clear |=> !flags_q[WRITEBACK_OUT_BIT];
	endproperty
	a_wb_clear: assert property (p_wb_clear) else $error("set then clear failed"); // [RULE_06]

	// with every mask bit zero the interrupt stays low
	property p_mask_off;
		@(posedge mclk) disable iff (!resetn)
		(mask_q == 32'h0000_0000) |-> !dma_irq_zero;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("interrupt while masked"); // [RULE_12]

	// while reset is held the flags and the interrupt sit at their reset values
	property p_reset_clear;
		@(posedge mclk)
		!resetn |-> (flags_q == CESG_FLAGS_RST) && !dma_irq_zero;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset value wrong"); // [RULE_01]
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// testbench: apb access, client events, sticky clear and interrupt of the status block
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
	$display("FAIL %s exp %h got %h", n, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cesg_pkg::*;
	logic mclk, resetn, psel, penable, pwrite, pready, pslverr, dma_irq_zero;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, dv, de, er, es, r, v, m;
	logic [32:0] q[$];
	logic [32:0] exp_v;
	int fail_count, num_checks;
	cesg_status cesg_status_inst(.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .desc_event(de), .desc_valid(dv), .eof_received(er),
		.eof_sent(es), .dma_irq_zero);
	// free-running 20 MHz clock
	initial begin
		mclk = 1'h0;
		forever #25 mclk = ~mclk;
	end
	task print_verdict;
		if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// one apb transfer; a read notes its expected {pslverr, prdata}
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		int n;
		n = 0;
		@(posedge mclk);
		if (!w) q.push_back(e);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do begin @(posedge mclk); n++; end while (pready !== 1'h1 && n < 20);
		if (n >= 20) begin fail_count++; print_verdict(); end
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// one-cycle pulse on the client event inputs
	task pulse(input logic [31:0] cv, ev, rx, tx);
		@(posedge mclk);
		dv <= cv;
		de <= ev;
		er <= rx;
		es <= tx;
		@(posedge mclk);
		{dv, de, er, es} <= 128'h0;
	endtask
	// irq is a registered level, so give it two edges to settle
	task irq_is(input logic e);
		repeat (2) @(posedge mclk);
		#1;
		`CHK("irq", e, dma_irq_zero)
	endtask
	// read results are taken at the access edge, oldest note first
	always @(posedge mclk) begin
		if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1 && pwrite === 1'h0) begin
			exp_v = (q.size() > 0) ? q.pop_front() : 33'h1FFFFFFFF;
			`CHK("read", exp_v, {pslverr, prdata})
		end
	end
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata, dv, de, er, es} = 'h0;
		fail_count = 0;
		num_checks = 0;
		void'($urandom(32'h69307E25));
		repeat (10) @(posedge mclk);
		resetn <= 1'h1;
		apb(1'h0, CESG_FLAGS_OFF, 32'h0, 33'h0);
		pulse(32'h0, 32'h0, 32'hFFFFFFFF, 32'h0);
		apb(1'h0, CESG_FLAGS_OFF, 32'h0, {1'h0, CESG_CAPTURE_MASK});
		apb(1'h0, CESG_LAST_OFF, 32'h0, {1'h0, CESG_CAPTURE_MASK});
		repeat (20) @(posedge mclk);
		apb(1'h0, CESG_FLAGS_OFF, 32'h0, {1'h0, CESG_CAPTURE_MASK});
		apb(1'h1, CESG_FLAGS_OFF, 32'hFFFFFFFF, 33'h0);
		pulse(32'h0, 32'h0, 32'h0, 32'hFFFFFFFF);
		apb(1'h0, CESG_FLAGS_OFF, 32'h0, {1'h0, CESG_FETCH_MASK});
		apb(1'h0, CESG_LAST_OFF, 32'h0, {1'h0, CESG_FETCH_MASK});
		// random partial clears leave exactly the unwritten flags
		for (int i = 0; i < 8; i++) begin
			r = $urandom();
			pulse(32'h0, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF);
			apb(1'h1, CESG_FLAGS_OFF, r, 33'h0);
			apb(1'h0, CESG_FLAGS_OFF, 32'h0, {1'h0, CESG_IMPL_MASK & ~r});
		end
		// a clear meeting an event in the same cycle loses to the event
		fork
			apb(1'h1, CESG_FLAGS_OFF, 32'hFFFFFFFF, 33'h0);
			begin
				@(posedge mclk);
				pulse(32'h0, 32'h0, 32'h0, 32'hFFFFFFFF);
			end
		join
		apb(1'h0, CESG_FLAGS_OFF, 32'h0, {1'h0, CESG_FETCH_MASK});
		// configured clients ignore end of frame and follow their own event
		v = $urandom() & CESG_IMPL_MASK;
		apb(1'h1, CESG_FLAGS_OFF, 32'hFFFFFFFF, 33'h0);
		pulse(v, 32'h0, 32'h0, 32'h0);
		apb(1'h0, CESG_EVSEL_OFF, 32'h0, {1'h0, v});
		pulse(32'h0, 32'h0, 32'hFFFFFFFF, 32'hFFFFFFFF);
		apb(1'h0, CESG_FLAGS_OFF, 32'h0, {1'h0, CESG_IMPL_MASK & ~v});
		pulse(32'h0, v, 32'h0, 32'h0);
		apb(1'h0, CESG_FLAGS_OFF, 32'h0, {1'h0, CESG_IMPL_MASK});
		// interrupt: raise by mask, drop by clear, raise again, drop by mask
		irq_is(1'h0);
		m = 32'h1 << (19 + $urandom_range(10));
		apb(1'h1, CESG_MASK_OFF, m, 33'h0);
		irq_is(1'h1);
		apb(1'h0, CESG_MASK_OFF, 32'h0, {1'h0, m});
		apb(1'h1, CESG_FLAGS_OFF, m, 33'h0);
		irq_is(1'h0);
		pulse(32'h0, m, 32'hFFFFFFFF, 32'hFFFFFFFF);
		irq_is(1'h1);
		apb(1'h1, CESG_MASK_OFF, 32'h0, 33'h0);
		irq_is(1'h0);
		apb(1'h0, 12'h090, 32'h0, {1'h1, 32'h0});
		// a mid-run reset returns every flag to zero
		resetn <= 1'h0;
		@(posedge mclk);
		resetn <= 1'h1;
		apb(1'h0, CESG_FLAGS_OFF, 32'h0, 33'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
